// >>> rtl/rx_frame_buffer.sv
`timescale 1ns/1ns
module rx_frame_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } buf_state_t;

  buf_state_t buf_reg;
  buf_state_t buf_next;

  ////////////////////////////////////////////////////////////////////////////
  // Read register sees a write in the same cycle, so the head is never stale
  always_comb begin
    buf_next = buf_reg;
    if (wr_en) begin
      buf_next.mem[wr_addr] = wr_data;
    end
    buf_next.rd = buf_next.mem[rd_addr];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  assign rd_data = buf_reg.rd;

endmodule

// >>> rtl/uart_receive_buffer_status.sv
`timescale 1ns/1ns
`include "uart_rx_defines.svh"

// Behaviour
// - Each data read pops the buffer; ninth bit and errors show next frame.
// - Receive-complete is one while any unread frame is buffered.
// - Clearing receiver enable flushes the buffer and clears receive-complete.
// - Interrupt requested while flag set, its enable set, global enable set.
// - Frame, overrun and parity errors are stored with their frame.
// - Software writes cannot change the three error flags.
// - Error flags never raise an interrupt.
// - Frame error is one when the first stop bit sampled low.
// - Only the first stop bit is checked, whatever the stop count.
// - Overrun when buffer full, frame waiting, and new start detected.
// - Overrun clears when a frame moves from shift register to buffer.
// - Parity checked only when enabled; type bit picks odd or even.
// - Parity computed over data, compared, mismatch stored with frame.
// - Parity error only if enabled at arrival; valid until data read.
// - Parity error reads the head frame's stored bit even while parity checking is disabled.
// - Disable is immediate, drops the frame, releases the input pin.
// - Sync to each start bit, then majority-filter every received bit.
// - Unused upper data bits read zero for short characters.
// - Frame transferred at first stop bit; second stop bit ignored.
// - Sixteen samples per bit normally, eight in double speed.
// - Start accepted on majority low of samples 8-10, or 4-6.
module uart_receive_buffer_status
  import uart_rx_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rxd_pin,
  input wire logic sample_en,
  input wire logic rx_enable_bit,
  input wire logic double_speed_bit,
  input wire logic [2:0] char_size_field,
  input wire logic parity_enable_bit,
  input wire logic parity_type_bit,
  input wire logic stop_bit_count_select,
  input wire logic rx_complete_irq_enable,
  input wire logic global_irq_enable,
  input wire logic data_read,
  output logic [7:0] rx_data,
  output logic rx_ninth_bit,
  output logic frame_error_flag,
  output logic overrun_flag,
  output logic parity_error_flag,
  output logic rx_complete_flag,
  output logic rx_irq,
  output logic rx_pin_override
);

  rx_regs_t rx_reg;
  rx_regs_t rx_next;
  logic buf_wr_en;
  frame_entry_t buf_wr_data;
  frame_entry_t head;
  logic pop;
  logic bit_val;
  logic [1:0] votes_now;
  logic [4:0] spb;
  logic [4:0] first_vote;
  logic [3:0] nbits;
  logic [1:0] cnt;

  // Entry width follows the struct, so a new status bit needs no edit here
  localparam int ENTRY_W = $bits(frame_entry_t);
  localparam int SLOTS = 2;
  localparam int PTR_W = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Data bits in a character
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == `RX_CHAR_NINE) begin
      char_bits = 4'h9;
    end else begin
      char_bits = `RX_CHAR_BASE + {2'h0, code[1:0]};
    end
  endfunction

  // Oversampling figures for the selected speed
  function automatic logic [4:0] samples_per_bit(input logic dbl);
    if (dbl) begin
      samples_per_bit = `RX_SPB_DOUBLE;
    end else begin
      samples_per_bit = `RX_SPB_NORMAL;
    end
  endfunction

  function automatic logic [4:0] first_vote_sample(input logic dbl);
    if (dbl) begin
      first_vote_sample = `RX_VOTE_DOUBLE;
    end else begin
      first_vote_sample = `RX_VOTE_NORMAL;
    end
  endfunction

  // Sample counter wraps to one at the end of each bit
  function automatic logic [4:0] next_sample(input logic [4:0] smp,
                                             input logic [4:0] per_bit);
    if (smp == per_bit) begin
      next_sample = 5'h01;
    end else begin
      next_sample = smp + 5'h01;
    end
  endfunction

  // One of the three centre samples of a bit
  function automatic logic in_vote_window(input logic [4:0] smp,
                                          input logic [4:0] first);
    return (smp >= first) && (smp <= first + 5'h02);
  endfunction

  // Last centre sample, where the bit is decided
  function automatic logic is_decision(input logic [4:0] smp,
                                       input logic [4:0] first);
    return smp == first + 5'h02;
  endfunction

  // Two of three high samples make a one; a short spike cannot win
  function automatic logic majority(input logic [1:0] highs);
    return highs >= 2'h2;
  endfunction

  // Room for the waiting frame once this cycle's pop is counted
  function automatic logic has_room(input logic [1:0] fill);
    return fill < `RX_BUF_DEPTH;
  endfunction

  // High when data and parity bit disagree with the chosen type
  function automatic logic parity_mismatch(input logic [8:0] bits,
                                           input logic pbit,
                                           input logic odd);
    return ^bits ^ pbit ^ odd;
  endfunction

  // Entry of a frame whose first stop bit has just been voted
  function automatic frame_entry_t make_entry(input logic [8:0] bits,
                                              input logic stop);
    frame_entry_t e;
    e = `RX_ENTRY_RESET;
    e.data = bits[7:0];
    e.ninth = bits[8];
    e.ferr = !stop;
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rx_next = rx_reg;
    buf_wr_en = 1'b0;
    buf_wr_data = '0;
    pop = 1'b0;
    bit_val = 1'b0;
    votes_now = 2'h0;
    cnt = rx_reg.count;
    nbits = char_bits(char_size_field);
    spb = samples_per_bit(double_speed_bit);
    first_vote = first_vote_sample(double_speed_bit);
    // Second stage alone reads the first; logic reads only sync2
    rx_next.sync1 = rxd_pin;
    rx_next.sync2 = rx_reg.sync1;
    rx_next.pin_override = rx_enable_bit;
    if (!rx_enable_bit) begin
      // Immediate: the frame in flight and all buffered frames are lost
      rx_next.state = ST_IDLE;
      rx_next.scnt = 5'h00;
      rx_next.votes = 2'h0;
      rx_next.hold_valid = 1'b0;
      rx_next.ovr_pending = 1'b0;
      rx_next.last_smp = `RX_IDLE_LEVEL;
      cnt = 2'h0;
      rx_next.rd_ptr = 1'b0;
      rx_next.wr_ptr = 1'b0;
    end else begin
      // A read pops the head; the next frame and its status follow
      pop = data_read && (rx_reg.count != 2'h0);
      if (pop) begin
        cnt = cnt - 2'h1;
        rx_next.rd_ptr = rx_reg.rd_ptr + 1'b1;
      end
      // Waiting frame enters the buffer as soon as a slot is free
      if (rx_reg.hold_valid && has_room(cnt)) begin
        buf_wr_en = 1'b1;
        buf_wr_data = rx_reg.hold;
        buf_wr_data.ovr = rx_reg.ovr_pending;
        rx_next.ovr_pending = 1'b0;
        rx_next.hold_valid = 1'b0;
        rx_next.wr_ptr = rx_reg.wr_ptr + 1'b1;
        cnt = cnt + 2'h1;
      end
      if (sample_en) begin
        rx_next.last_smp = rx_reg.sync2;
        if (rx_reg.state == ST_IDLE) begin
          // Falling edge restarts the bit clock for every frame
          if (rx_reg.last_smp && !rx_reg.sync2) begin
            rx_next.state = ST_START;
            rx_next.scnt = 5'h02;
            rx_next.votes = 2'h0;
            // Full buffer plus waiting frame: that frame is lost
            if (rx_next.hold_valid) begin
              rx_next.ovr_pending = 1'b1;
              rx_next.hold_valid = 1'b0;
            end
          end
        end else begin
          rx_next.scnt = next_sample(rx_reg.scnt, spb);
          votes_now = rx_reg.votes;
          if (in_vote_window(rx_reg.scnt, first_vote) && rx_reg.sync2) begin
            votes_now = rx_reg.votes + 2'h1;
          end
          rx_next.votes = votes_now;
          if (is_decision(rx_reg.scnt, first_vote)) begin
            // Two of three centre samples decide the bit
            bit_val = majority(votes_now);
            rx_next.votes = 2'h0;
            case (rx_reg.state)
              ST_START: begin
                if (bit_val) begin
                  rx_next.state = ST_IDLE;
                end else begin
                  rx_next.state = ST_DATA;
                  rx_next.bit_idx = 4'h0;
                  rx_next.shift = 9'h000;
                end
              end
              ST_DATA: begin
                rx_next.shift[rx_reg.bit_idx] = bit_val;
                rx_next.bit_idx = rx_reg.bit_idx + 4'h1;
                if (rx_reg.bit_idx == nbits - 4'h1) begin
                  // Enable is latched per frame, so later changes leave it
                  rx_next.par_en = parity_enable_bit;
                  rx_next.state = ST_STOP;
                  if (parity_enable_bit) begin
                    rx_next.state = ST_PARITY;
                  end
                end
              end
              ST_PARITY: begin
                rx_next.pbit = bit_val;
                rx_next.state = ST_STOP;
              end
              ST_STOP: begin
                // First stop bit ends the frame; a second one is idle time
                rx_next.state = ST_IDLE;
                rx_next.hold = make_entry(rx_reg.shift, bit_val);
                // Even on type zero, odd on type one
                rx_next.hold.perr = rx_reg.par_en &
                  parity_mismatch(rx_reg.shift, rx_reg.pbit,
                  parity_type_bit);
                rx_next.par_en = 1'b0;
                rx_next.hold_valid = 1'b1;
              end
              default: begin
                rx_next.state = ST_IDLE;
              end
            endcase
          end
        end
      end
    end
    rx_next.count = cnt;
    rx_next.complete = cnt != 2'h0;
    // Only the complete flag feeds the request, never the error flags
    rx_next.irq = rx_complete_irq_enable & global_irq_enable &
      (cnt != 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_reg <= '0;
      rx_reg.sync1 <= `RX_IDLE_LEVEL;
      rx_reg.sync2 <= `RX_IDLE_LEVEL;
      rx_reg.last_smp <= `RX_IDLE_LEVEL;
      rx_reg.state <= ST_IDLE;
      rx_reg.hold <= `RX_ENTRY_RESET;
    end else begin
      rx_reg <= rx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and data of a frame share one entry, so they change together
  rx_frame_buffer #(
    .WIDTH(ENTRY_W),
    .DEPTH(SLOTS),
    .AW(PTR_W)
  ) frame_buffer (
    .clock(clock),
    .rst(rst),
    .wr_en(buf_wr_en),
    .wr_addr(rx_reg.wr_ptr),
    .wr_data(buf_wr_data),
    .rd_addr(rx_next.rd_ptr),
    .rd_data(head)
  );

  // No write path to the flags exists, so software cannot alter them
  assign rx_data = head.data;
  assign rx_ninth_bit = head.ninth;
  assign frame_error_flag = head.ferr;
  assign overrun_flag = head.ovr;
  assign parity_error_flag = head.perr;
  assign rx_complete_flag = rx_reg.complete;
  assign rx_irq = rx_reg.irq;
  assign rx_pin_override = rx_reg.pin_override;

endmodule

// >>> shared/uart_rx_defines.svh
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH

// Receive buffer depth in frames; pointer arithmetic assumes a power of two
`define RX_BUF_DEPTH 2'd2

// Oversampling per bit and first voting sample, normal and double speed
`define RX_SPB_NORMAL 5'h10
`define RX_SPB_DOUBLE 5'h08
`define RX_VOTE_NORMAL 5'h08
`define RX_VOTE_DOUBLE 5'h04

// Character size code that selects nine data bits
`define RX_CHAR_NINE 3'h7
// Fewest data bits, for codes 0 to 3
`define RX_CHAR_BASE 4'h5

// Reset values
`define RX_ENTRY_RESET 12'h000
`define RX_IDLE_LEVEL 1'h1

`endif

// >>> shared/uart_rx_pkg.sv
package uart_rx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } rx_state_t;

  // One buffered frame with the status that travels with it
  typedef struct packed {
    logic perr;
    logic ovr;
    logic ferr;
    logic ninth;
    logic [7:0] data;
  } frame_entry_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last_smp;
    rx_state_t state;
    logic [4:0] scnt;
    logic [1:0] votes;
    logic [3:0] bit_idx;
    logic [8:0] shift;
    logic pbit;
    logic par_en;
    frame_entry_t hold;
    logic hold_valid;
    logic ovr_pending;
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    logic complete;
    logic irq;
    logic pin_override;
  } rx_regs_t;

endpackage

// >>> testbench/serial_tx_model.sv
`timescale 1ns/1ns
module serial_tx_model (
  input wire logic clock,
  input wire logic sample_en,
  input wire logic dbl,
  output logic rxd
);
  // Line idles high, as with a pull-up
  initial rxd = 1'h1;
  task automatic hold(input logic v, input int n);
    @(negedge clock);
    rxd = v;
    repeat (n) @(posedge clock iff sample_en);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Start, data LSB first, optional parity, one stop bit
  task automatic send(input logic [8:0] d, input int nb,
                      input logic pe, po, bad, stopv);
    int spb;
    spb = dbl ? 8 : 16;
    hold(1'h0, spb);
    for (int i = 0; i < nb; i++) hold(d[i], spb);
    if (pe) hold((^(d & ((9'h001 << nb) - 9'h001))) ^ po ^ bad, spb);
    hold(stopv, spb);
    hold(1'h1, 1);
  endtask
  // Short low glitch, too short to win the start vote
  task automatic spike(input int n);
    hold(1'h0, n);
    hold(1'h1, 24);
  endtask
endmodule

// >>> testbench/uart_receive_buffer_status_bench.sv
`timescale 1ns/1ns
module uart_receive_buffer_status_bench;
  logic clock, rst, rxd_pin, sample_en, rx_enable_bit, double_speed_bit;
  logic [2:0] char_size_field;
  logic parity_enable_bit, parity_type_bit, stop_bit_count_select;
  logic rx_complete_irq_enable, global_irq_enable, data_read;
  logic [7:0] rx_data;
  logic rx_ninth_bit, frame_error_flag, overrun_flag, parity_error_flag;
  logic rx_complete_flag, rx_irq, rx_pin_override;
  logic [2:0] errs;
  int num_errors = 0;
  int compares = 0;
  assign errs = {frame_error_flag, overrun_flag, parity_error_flag};
  uart_receive_buffer_status i_dut (.clock, .rst, .rxd_pin, .sample_en,
    .rx_enable_bit, .double_speed_bit, .char_size_field, .parity_enable_bit,
    .parity_type_bit, .stop_bit_count_select, .rx_complete_irq_enable,
    .global_irq_enable, .data_read, .rx_data, .rx_ninth_bit,
    .frame_error_flag, .overrun_flag, .parity_error_flag, .rx_complete_flag,
    .rx_irq, .rx_pin_override);
  serial_tx_model i_tx (.clock, .sample_en, .dbl(double_speed_bit),
    .rxd(rxd_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_flag(input logic exp);
    int n;
    n = 0;
    @(negedge clock);
    while (rx_complete_flag !== exp && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n == 4000) begin
      num_errors++;
      final_report();
    end
  endtask
  // Status and ninth bit are read before the pop
  task automatic head(input logic [8:0] d, input logic [2:0] err);
    check("rx_data", 9'(rx_data), 9'(d[7:0]));
    check("rx_ninth_bit", 9'(rx_ninth_bit), 9'(d[8]));
    check("error flags", 9'(errs), 9'(err));
  endtask
  task automatic pop();
    @(negedge clock);
    data_read = 1'h1;
    @(negedge clock);
    data_read = 1'h0;
    @(negedge clock);
  endtask
  task automatic one(input logic [8:0] d, input int nb, input logic bad,
                     input logic stopv, input logic [2:0] err);
    i_tx.send(d, nb, parity_enable_bit, parity_type_bit, bad, stopv);
    wait_flag(1'h1);
    check("rx_irq", 9'(rx_irq), 9'h001);
    head(d & ((9'h001 << nb) - 9'h001), err);
    pop();
    check("rx_complete_flag", 9'(rx_complete_flag), 9'h000);
    check("rx_irq", 9'(rx_irq), 9'h000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_sizes();
    for (int c = 0; c < 8; c++) begin
      char_size_field = 3'(c);
      one(9'h1a5, (c == 7) ? 9 : c % 4 + 5, 1'h0, 1'h1, 3'h0);
    end
  endtask
  task automatic t_parity();
    parity_enable_bit = 1'h1;
    for (int p = 0; p < 4; p++) begin
      parity_type_bit = p[0];
      one(9'h05a, 8, p[1], 1'h1, {2'h0, p[1]});
    end
    parity_enable_bit = 1'h0;
    one(9'h0c3, 8, 1'h0, 1'h1, 3'h0);
    stop_bit_count_select = 1'h1;
    one(9'h081, 8, 1'h0, 1'h0, 3'h4);
  endtask
  // Two buffered, third waits, fourth start loses the third
  task automatic t_overrun();
    for (int f = 1; f < 5; f++) i_tx.send(9'(f), 8, 1'h0, 1'h0, 1'h0, 1'h1);
    wait_flag(1'h1);
    head(9'h001, 3'h0);
    pop();
    head(9'h002, 3'h0);
    pop();
    head(9'h004, 3'h2);
    for (int n = 0; n < 4 && rx_complete_flag === 1'h1; n++) pop();
    check("rx_complete_flag", 9'(rx_complete_flag), 9'h000);
  endtask
  task automatic t_disable();
    i_tx.send(9'h011, 8, 1'h0, 1'h0, 1'h0, 1'h1);
    wait_flag(1'h1);
    global_irq_enable = 1'h0;
    @(negedge clock);
    @(negedge clock);
    check("rx_irq", 9'(rx_irq), 9'h000);
    global_irq_enable = 1'h1;
    rx_enable_bit = 1'h0;
    @(negedge clock);
    @(negedge clock);
    check("rx_complete_flag", 9'(rx_complete_flag), 9'h000);
    check("rx_pin_override", 9'(rx_pin_override), 9'h000);
    rx_enable_bit = 1'h1;
    fork
      // Line stays high after the cut, so no false start follows
      i_tx.send(9'h0fe, 8, 1'h0, 1'h0, 1'h0, 1'h1);
      begin
        repeat (120) @(negedge clock);
        rx_enable_bit = 1'h0;
        @(negedge clock);
        rx_enable_bit = 1'h1;
      end
    join
    repeat (40) @(negedge clock);
    check("rx_complete_flag", 9'(rx_complete_flag), 9'h000);
  endtask
  task automatic t_noise();
    for (int s = 0; s < 2; s++) begin
      double_speed_bit = s[0];
      i_tx.spike(s ? 2 : 4);
      check("rx_complete_flag", 9'(rx_complete_flag), 9'h000);
      one(9'h03c, 8, 1'h0, 1'h1, 3'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  always @(negedge clock) sample_en <= ~sample_en;
  initial begin
    {rst, sample_en, rx_enable_bit, double_speed_bit} = 4'h8;
    {parity_enable_bit, parity_type_bit, stop_bit_count_select} = 3'h0;
    {rx_complete_irq_enable, global_irq_enable, data_read} = 3'h6;
    char_size_field = 3'h3;
    // Flag positions have no write path and are never written
    repeat (2) @(negedge clock);
    rst = 1'h0;
    rx_enable_bit = 1'h1;
    repeat (8) @(negedge clock);
    t_sizes();
    char_size_field = 3'h3;
    t_parity();
    t_overrun();
    t_disable();
    t_noise();
    final_report();
  end
endmodule
bind uart_receive_buffer_status uart_rx_chk i_chk (.clock, .rst, .rxd_pin,
  .sample_en, .rx_enable_bit, .double_speed_bit, .char_size_field,
  .parity_enable_bit, .parity_type_bit, .stop_bit_count_select,
  .rx_complete_irq_enable, .global_irq_enable, .data_read, .rx_data,
  .rx_ninth_bit, .frame_error_flag, .overrun_flag, .parity_error_flag,
  .rx_complete_flag, .rx_irq, .rx_pin_override);

// >>> testbench/uart_rx_chk.sv
`timescale 1ns/1ns
module uart_rx_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic rxd_pin,
  input wire logic sample_en,
  input wire logic rx_enable_bit,
  input wire logic double_speed_bit,
  input wire logic [2:0] char_size_field,
  input wire logic parity_enable_bit,
  input wire logic parity_type_bit,
  input wire logic stop_bit_count_select,
  input wire logic rx_complete_irq_enable,
  input wire logic global_irq_enable,
  input wire logic data_read,
  input wire logic [7:0] rx_data,
  input wire logic rx_ninth_bit,
  input wire logic frame_error_flag,
  input wire logic overrun_flag,
  input wire logic parity_error_flag,
  input wire logic rx_complete_flag,
  input wire logic rx_irq,
  input wire logic rx_pin_override
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_idle_head;
    rx_complete_flag && !data_read && rx_enable_bit;
  endsequence
  sequence s_reenable;
    $rose(rx_enable_bit);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_irq_gated: assert property (rx_irq == (rx_complete_flag &&
    $past(rx_complete_irq_enable) && $past(global_irq_enable)))
    else $error("rx_irq not gated by flag and enables");
  a_irq_masked: assert property (!global_irq_enable |=> !rx_irq)
    else $error("rx_irq while globally masked");
  a_errors_no_irq: assert property (!rx_complete_flag |-> !rx_irq)
    else $error("rx_irq without a buffered frame");
  a_disable_flush: assert property (!rx_enable_bit |=>
    !rx_complete_flag && !rx_irq) else $error("flag survived disable");
  a_pin_release: assert property (!rx_enable_bit [*2] |->
    !rx_pin_override) else $error("pin still owned while disabled");
  a_head_stands: assert property (s_idle_head |=> rx_complete_flag &&
    $stable(rx_data) && $stable(rx_ninth_bit) && $stable({frame_error_flag,
    overrun_flag, parity_error_flag})) else $error("head moved unread");
  a_reenable_empty: assert property (s_reenable |->
    !rx_complete_flag [*8]) else $error("frame kept across disable");
  a_flag_needs_en: assert property ($rose(rx_complete_flag) |->
    $past(rx_enable_bit)) else $error("flag rose while disabled");
endmodule
